/* cdc_seq_map.svh */
// register offsets, reset values and timing counts of the cdc sequencer
`ifndef CDC_SEQ_MAP_SVH
`define CDC_SEQ_MAP_SVH
// register byte addresses
`define ADDR_CONFIG    8'h00
`define ADDR_SEQUENCE  8'h04
`define ADDR_TIMES     8'h08
`define ADDR_PERIOD    8'h0C
`define ADDR_COMMAND   8'h10
`define ADDR_DSP_PARAM 8'h14
`define ADDR_STATUS    8'h18
// bit positions
`define OPCODE_START_BIT 0
`define DSP_FLAG_BIT     1
// reset values
`define CONFIG_RESET   32'h0008_1003
`define SEQUENCE_RESET 32'h0000_0000
`define TIMES_RESET    32'h0010_0000
// limits of fields
`define REF_CAP_MIN    5'h01
`define RES_LOW_MAX    3'h4
// cycle time base, in ns, and its count of 20 ns clocks
`define CLOCK_NS       20
`define CYCLE_TIME_NS  1000
`define CYCLE_TICKS    ((`CYCLE_TIME_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`endif

/* cdc_seq_pkg.sv */
// types shared by the cdc sequencer and its cycle timer
package cdc_seq_pkg;
   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,  // port grounded
      PH_PRE  = 3'b001,  // charge through series resistor
      PH_FULL = 3'b010,  // charge straight to supply
      PH_DIS  = 3'b011,  // discharge through discharge resistor
      PH_GND  = 3'b100   // tail grounding after discharge
   } phase_t;
   typedef enum logic [2:0] {
      CV_IDLE = 3'b000,
      CV_WAIT = 3'b001,
      CV_STEP = 3'b010,
      CV_RUN  = 3'b011,
      CV_DONE = 3'b100
   } conv_t;
   typedef struct packed {
      logic [7:0] spare;
      logic [4:0] ref_cap;
      logic       legacy_mode;
      logic       slow_discharge_resistor_enable;
      logic [1:0] conversion_trigger_source;
      logic       comp_r;
      logic       comp_ext;
      logic       comp_int;
      logic       ref_internal;
      logic       differential;
      logic       floating;
      logic       spare0;
      logic [7:0] port_enable;
   } config_t;
   typedef struct packed {
      logic [18:0] spare;
      logic [1:0]  res_high_sel;
      logic [2:0]  res_low_sel;
      logic [3:0]  avg_count;
      logic [3:0]  fake_count;
   } sequence_t;
   typedef struct packed {
      logic [1:0] spare;
      logic [9:0] discharge;
      logic [9:0] fullcharge;
      logic [9:0] precharge;
   } times_t;
   typedef struct packed {
      logic [9:0] precharge;
      logic [9:0] fullcharge;
      logic [9:0] discharge;
      logic       legacy;
   } cycle_cfg_t;
   typedef struct packed {
      phase_t      phase;
      logic [10:0] cnt;
      logic        timing;
      logic        done;
   } cyc_state_t;
   typedef struct packed {
      config_t    cfg;
      sequence_t  sq;
      times_t     tm;
      logic [15:0] period;
      logic [15:0] dsp_param;
      conv_t      conv;
      logic [2:0] unit;
      logic [2:0] sub;
      logic       cint;
      logic [4:0] seq_cnt;
      logic [5:0] tick_cnt;
      logic       tick;
      logic [15:0] per_cnt;
      logic       timer_fire;
      logic       start_cyc;
      logic [9:0] mask;
      logic [31:0] rdata;
      logic       done;
      logic       busy;
      logic [4:0] res_low;
      logic [3:0] res_high;
      logic [4:0] ref_cap;
      logic       slow_en;
   } top_state_t;
endpackage

/* cdc_cycle_timer.sv */
// one measuring cycle: pre-charge, full charge, discharge, grounding
`timescale 1ns/1ps
module cdc_cycle_timer (
   input  wire logic                    i_clock,   // system clock
   input  wire logic                    i_rst_n,   // async reset, low
   input  wire logic                    i_tick,    // cycle time base
   input  wire logic                    i_start,   // begin one cycle
   input  wire cdc_seq_pkg::cycle_cfg_t i_cfg,     // phase lengths
   input  wire logic                    i_reached, // comparator hit
   output      cdc_seq_pkg::phase_t     o_phase,   // current phase
   output      logic                    o_timing,  // tdc window open
   output      logic                    o_done     // cycle finished
);
   import cdc_seq_pkg::*;

   cyc_state_t s;  // registered state
   cyc_state_t n;  // next state

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   // enter discharge; a zero setting is not allowed, so treat it as one
   function automatic cyc_state_t go_dis(cyc_state_t st, cycle_cfg_t c);
      cyc_state_t r;
      r        = st;
      r.phase  = PH_DIS;
      r.timing = 1'b1;
      r.cnt    = (c.discharge == 10'h000) ? 11'h001 :
                 {1'b0, c.discharge};
      return r;
   endfunction

   // enter full charge, or skip it when its setting is zero
   function automatic cyc_state_t go_full(cyc_state_t st, cycle_cfg_t c);
      cyc_state_t r;
      r = st;
      if (c.fullcharge != 10'h000) begin
         r.phase = PH_FULL;
         r.cnt   = {1'b0, c.fullcharge} + 11'h001;
      end else begin
         r = go_dis(st, c);
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // phase sequencing
   // ----------------------------------------------------------------
   // each phase lasts cnt+1 ticks; the tdc window closes on the hit
   always_comb begin
      n      = s;
      n.done = 1'b0;
      case (s.phase)
         PH_IDLE: begin
            if (i_start) begin
               if (i_cfg.precharge != 10'h000) begin
                  n.phase = PH_PRE;
                  n.cnt   = {1'b0, i_cfg.precharge} - 11'h001;
               end else begin
                  n = go_full(s, i_cfg);
               end
            end
         end
         PH_PRE: begin
            if (i_tick && s.cnt == 11'h000) begin
               n = go_full(s, i_cfg);
            end else if (i_tick) begin
               n.cnt = s.cnt - 11'h001;
            end
         end
         PH_FULL: begin
            if (i_tick && s.cnt == 11'h000) begin
               n = go_dis(s, i_cfg);
            end else if (i_tick) begin
               n.cnt = s.cnt - 11'h001;
            end
         end
         PH_DIS: begin
            if (s.timing && i_reached && i_cfg.legacy) begin
               n.timing = 1'b0; // ground at once, next port may charge
               n.phase  = PH_IDLE;
               n.done   = 1'b1;
            end else begin
               if (i_reached) begin
                  n.timing = 1'b0; // hit seen, keep discharging
               end
               if (i_tick && s.cnt == 11'h000) begin
                  n.phase  = PH_GND;
                  n.timing = 1'b0;
               end else if (i_tick) begin
                  n.cnt = s.cnt - 11'h001;
               end
            end
         end
         PH_GND: begin
            if (i_tick) begin
               n.phase = PH_IDLE;
               n.done  = 1'b1;
            end
         end
         default: begin
            n.phase = PH_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign o_phase  = s.phase;
   assign o_timing = s.timing;
   assign o_done   = s.done;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_dis_full_period: assert property (
      (s.phase == PH_DIS && i_tick && s.cnt == 11'h000 && !i_cfg.legacy)
      |=> (s.phase == PH_GND && !s.timing))
      else $error("discharge did not end in grounding");
   chk_legacy_ground: assert property (
      (s.phase == PH_DIS && s.timing && i_reached && i_cfg.legacy)
      |=> (s.phase == PH_IDLE && s.done))
      else $error("legacy hit did not ground the port");
   chk_skip_precharge: assert property (
      (s.phase == PH_IDLE && i_start && i_cfg.precharge == 10'h000)
      |=> (s.phase != PH_PRE && s.phase != PH_IDLE))
      else $error("pre-charge not skipped");
endmodule

/* cdc_measurement_sequencer.sv */
// capacitance converter sequencer: cycles, sequences and conversions
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "cdc_seq_map.svh"
module cdc_measurement_sequencer (
   input  wire logic                i_clock,       // 50 MHz clock
   input  wire logic                i_rst_n,       // async reset, low
   input  wire logic [7:0]          i_addr,        // register address
   input  wire logic [31:0]         i_wdata,       // write data
   input  wire logic                i_wr,          // write strobe
   input  wire logic                i_rd,          // read strobe
   output      logic [31:0]         o_rdata,       // read data
   input  wire logic                i_pin_trigger, // pin start pulse
   input  wire logic                i_dsp_trigger, // dsp start pulse
   input  wire logic                i_dsp_end,     // dsp program ended
   input  wire logic                i_reached,     // comparator hit
   output      cdc_seq_pkg::phase_t o_phase,       // cycle phase
   output      logic                o_tdc_timing,  // tdc window
   output      logic [9:0]          o_port_switch, // port switches
   output      logic [4:0]          o_res_low,     // set 1 resistor
   output      logic [3:0]          o_res_high,    // set 2 resistor
   output      logic                o_slow_res_en, // 1 MOhm enable
   output      logic [4:0]          o_ref_cap,     // internal ref pF
   output      logic                o_conv_done,   // end of conversion
   output      logic                o_busy         // conversion runs
);
   import cdc_seq_pkg::*;

   localparam logic [5:0] TICK_LAST = 6'(`CYCLE_TICKS - 1);

   top_state_t s;          // registered state
   top_state_t n;          // next state
   logic [7:0] unit_en;    // measurable units
   logic [3:0] nu;         // next unit, valid in bit 3
   logic [2:0] sub_count;  // measurements per unit
   logic [4:0] seq_last;   // index of last sequence
   logic       use_int;    // internal reference allowed
   logic       timed;      // conversion period set
   logic       stretched;  // one sequence per timer period
   logic       trig;       // any start condition
   logic       cyc_done;   // cycle timer finished
   cycle_cfg_t cyc_cfg;    // lengths for the cycle timer

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);

   // ----------------------------------------------------------------
   // sequence planning
   // ----------------------------------------------------------------
   // grounded: unit k is port k; floating: unit k is pair 2k, 2k+1; internal reference puts unit 0 on switch 8 (pair 8, 9)
   for (genvar g = 0; g < 8; g++) begin : g_unit
      if (g == 0) begin : g_ref
         assign unit_en[g] = 1'b1;
      end else if (g < 4) begin : g_pair
         assign unit_en[g] = s.cfg.floating ?
            (s.cfg.port_enable[2*g] & s.cfg.port_enable[2*g+1]) :
            s.cfg.port_enable[g];
      end else begin : g_single
         assign unit_en[g] = ~s.cfg.floating & s.cfg.port_enable[g];
      end
   end

   // lowest enabled unit above the current one
   function automatic logic [3:0] next_unit(logic [7:0] en,
                                            logic [2:0] cur);
      logic [3:0] r;
      r = 4'h0;
      for (int k = 7; k >= 1; k--) begin
         if (en[k] && (3'(k) > cur)) begin
            r = {1'b1, 3'(k)};
         end
      end
      return r;
   endfunction

   // switches closed for one measurement of a unit
   function automatic logic [9:0] step_mask(logic [2:0] u, logic [2:0] sb,
                                            logic fl, logic ir);
      logic [9:0] a;
      logic [9:0] r;
      a = (u == 3'h0) ? (ir ? 10'h100 : 10'h001) : 10'h000;
      r = 10'h000;
      if (fl) begin
         if (u != 3'h0) begin
            a = 10'h001 << {u, 1'b0};
         end
         case (sb)
            3'h0, 3'h3: r = a;
            3'h1, 3'h4: r = a << 1;
            default:    r = a | (a << 1);
         endcase
      end else begin
         r = (u == 3'h0) ? a : (10'h001 << u);
      end
      return r;
   endfunction

   assign use_int = s.cfg.ref_internal & ~s.cfg.differential;
   assign timed     = (s.period != 16'h0000);
   assign stretched = timed &&
                      s.cfg.conversion_trigger_source == 2'h0;
   assign seq_last  = {1'b0, s.sq.fake_count} +
                      {1'b0, s.sq.avg_count};

   // measurements per unit, by sensor kind and compensation
   always_comb begin
      if (s.cfg.floating) begin
         sub_count = s.cfg.comp_ext ?
                     (s.cfg.comp_r ? 3'h5 : 3'h3) : 3'h2;
      end else begin
         sub_count = s.cfg.comp_r ? 3'h2 : 3'h1;
      end
   end

   // start sources; only looked at while idle, so busy ignores them
   assign trig = (i_wr && i_addr == `ADDR_COMMAND &&
                  i_wdata[`OPCODE_START_BIT])
      || i_dsp_trigger
      || (s.dsp_param[`DSP_FLAG_BIT] && i_dsp_end)
      || (s.cfg.conversion_trigger_source == 2'h3 && !timed &&
          i_pin_trigger)
      || (s.cfg.conversion_trigger_source == 2'h2 && timed &&
          s.timer_fire)
      || (s.cfg.conversion_trigger_source == 2'h1 && !timed && s.done);

   assign cyc_cfg = '{precharge:  s.tm.precharge,
                      fullcharge: s.tm.fullcharge,
                      discharge:  s.tm.discharge,
                      legacy:     s.cfg.legacy_mode};

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      n            = s;
      n.rdata      = 32'h0000_0000;
      n.done       = 1'b0;
      n.start_cyc  = 1'b0;
      n.tick       = 1'b0;
      n.timer_fire = 1'b0;
      nu           = next_unit(unit_en, s.unit);
      // cycle time base divider
      if (s.tick_cnt == TICK_LAST) begin
         n.tick_cnt = 6'h00;
         n.tick     = 1'b1;
      end else begin
         n.tick_cnt = s.tick_cnt + 6'h01;
      end
      // conversion timer, counted in cycle ticks
      if (!timed) begin
         n.per_cnt = 16'h0000;
      end else if (s.tick && s.per_cnt == s.period - 16'h0001) begin
         n.per_cnt    = 16'h0000;
         n.timer_fire = 1'b1;
      end else if (s.tick) begin
         n.per_cnt = s.per_cnt + 16'h0001;
      end
      // register writes
      if (i_wr) begin
         case (i_addr)
            `ADDR_CONFIG:    n.cfg       = config_t'(i_wdata);
            `ADDR_SEQUENCE:  n.sq        = sequence_t'(i_wdata);
            `ADDR_TIMES:     n.tm        = times_t'(i_wdata);
            `ADDR_PERIOD:    n.period    = i_wdata[15:0];
            `ADDR_DSP_PARAM: n.dsp_param = i_wdata[15:0];
            default: ;  // command, status and unmapped: no storage
         endcase
      end
      // register reads, data in the next cycle only
      if (i_rd) begin
         case (i_addr)
            `ADDR_CONFIG:    n.rdata = s.cfg;
            `ADDR_SEQUENCE:  n.rdata = s.sq;
            `ADDR_TIMES:     n.rdata = s.tm;
            `ADDR_PERIOD:    n.rdata = {16'h0000, s.period};
            `ADDR_DSP_PARAM: n.rdata = {16'h0000, s.dsp_param};
            `ADDR_STATUS:    n.rdata = {16'h0000, s.busy, s.conv,
                                        s.cint, s.unit, s.sub, s.seq_cnt};
            default:         n.rdata = 32'h0000_0000;
         endcase
      end
      // resistor and reference selections follow the settings
      n.res_low  = 5'h01 << ((s.sq.res_low_sel > `RES_LOW_MAX) ?
                   `RES_LOW_MAX : s.sq.res_low_sel);
      n.res_high = 4'h1 << s.sq.res_high_sel;
      n.slow_en  = s.cfg.slow_discharge_resistor_enable;
      n.ref_cap  = (s.cfg.ref_cap == 5'h00) ? `REF_CAP_MIN :
                   s.cfg.ref_cap;
      // conversion control
      case (s.conv)
         CV_IDLE: begin
            if (trig) begin
               n.busy    = 1'b1;
               n.seq_cnt = 5'h00;
               n.unit    = 3'h0;
               n.sub     = 3'h0;
               n.cint    = 1'b0;
               n.conv    = stretched ? CV_WAIT : CV_STEP;
            end
         end
         CV_WAIT: begin
            if (s.timer_fire) begin
               n.conv = CV_STEP;
            end
         end
         CV_STEP: begin
            // internal step keeps every switch open
            n.mask = s.cint ? 10'h000 :
                     step_mask(s.unit, s.sub, s.cfg.floating,
                               use_int);
            n.start_cyc = 1'b1;
            n.conv      = CV_RUN;
         end
         CV_RUN: begin
            if (cyc_done) begin
               n.mask = 10'h000;
               if (!s.cint && (s.sub + 3'h1 < sub_count)) begin
                  n.sub  = s.sub + 3'h1;
                  n.conv = CV_STEP;
               end else if (!s.cint && nu[3]) begin
                  n.unit = nu[2:0];
                  n.sub  = 3'h0;
                  n.conv = CV_STEP;
               end else if (!s.cint && s.cfg.comp_int) begin
                  n.cint = 1'b1;
                  n.conv = CV_STEP;
               end else if (s.seq_cnt == seq_last) begin
                  n.conv = CV_DONE;
               end else begin
                  n.seq_cnt = s.seq_cnt + 5'h01;
                  n.unit    = 3'h0;
                  n.sub     = 3'h0;
                  n.cint    = 1'b0;
                  n.conv    = stretched ? CV_WAIT : CV_STEP;
               end
            end
         end
         CV_DONE: begin
            n.done = 1'b1;
            n.busy = 1'b0;
            n.conv = CV_IDLE;
         end
         default: begin
            n.conv = CV_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s       <= '0;
         s.cfg   <= config_t'(`CONFIG_RESET);
         s.sq    <= sequence_t'(`SEQUENCE_RESET);
         s.tm    <= times_t'(`TIMES_RESET);
         s.ref_cap  <= `REF_CAP_MIN;
         s.res_low  <= 5'h01;
         s.res_high <= 4'h1;
      end else begin
         s <= n;
      end
   end

   // ----------------------------------------------------------------
   // cycle timer and outputs
   // ----------------------------------------------------------------
   cdc_cycle_timer u_cycle (
      .i_clock   (i_clock),
      .i_rst_n   (i_rst_n),
      .i_tick    (s.tick),
      .i_start   (s.start_cyc),
      .i_cfg     (cyc_cfg),
      .i_reached (i_reached),
      .o_phase   (o_phase),
      .o_timing  (o_tdc_timing),
      .o_done    (cyc_done)
   );

   assign o_rdata       = s.rdata;
   assign o_port_switch = s.mask;
   assign o_res_low     = s.res_low;
   assign o_res_high    = s.res_high;
   assign o_slow_res_en = s.slow_en;
   assign o_ref_cap     = s.ref_cap;
   assign o_conv_done   = s.done;
   assign o_busy        = s.busy;

   // checks
   chk_done_single: assert property (
      o_conv_done |-> (!o_busy ##1 !o_conv_done))
      else $error("completion flag not a single pulse");
   chk_busy_ignore: assert property (
      (s.conv == CV_RUN && !cyc_done && trig)
      |=> (s.conv == CV_RUN && $stable(s.seq_cnt)))
      else $error("trigger disturbed a running conversion");
   chk_start_taken: assert property (
      (s.conv == CV_IDLE && trig) |=> (o_busy && s.seq_cnt == 5'h00))
      else $error("idle trigger not taken");
   chk_pin_single: assert property (
      (s.conv == CV_IDLE && i_pin_trigger && !timed &&
       s.cfg.conversion_trigger_source == 2'h3) |=> o_busy)
      else $error("pin trigger did not start");
   chk_timer_start: assert property (
      (s.conv == CV_IDLE && s.timer_fire && timed &&
       s.cfg.conversion_trigger_source == 2'h2) |=> o_busy)
      else $error("timer did not start conversion");
   chk_dsp_end: assert property (
      (s.conv == CV_IDLE && i_dsp_end && s.dsp_param[`DSP_FLAG_BIT])
      |=> o_busy)
      else $error("dsp end did not start conversion");
   chk_cint_open: assert property (
      (s.conv == CV_RUN && s.cint) |-> (o_port_switch == 10'h000))
      else $error("port switch closed in internal step");
   chk_ref_first: assert property (
      (s.conv == CV_STEP && s.unit == 3'h0 && s.sub == 3'h0 && !s.cint
       && !s.cfg.floating)
      |=> (o_port_switch == (use_int ? 10'h100 : 10'h001)))
      else $error("sequence did not open with reference");
   chk_ref_single: assert property (
      (o_port_switch[9:8] != 2'b00) |-> $past(use_int, 2))
      else $error("internal reference with differential sensor");
endmodule

/* cdc_sensor_model.sv */
// sensor side: comparator answers a set time after discharge begins
`timescale 1ns/1ps
module cdc_sensor_model (
   input  wire logic       i_clock,  // system clock
   input  wire logic [2:0] i_phase,  // cycle phase of the sequencer
   output      logic       o_reached // trigger level reached
);
   logic [7:0] cnt_q; // clocks spent in discharge
   // ----------------------------
   // discharge timer
   // ----------------------------
   always @(posedge i_clock) begin
      cnt_q <= (i_phase == 3'h3) ? cnt_q + 8'h01 : 8'h00;
   end
   // hit comes well inside the shortest discharge window
   assign o_reached = (cnt_q == 8'h28);
endmodule

/* tb_top.sv */
// self-checking bench of the cdc sequencer
`timescale 1ns/1ps
`include "cdc_seq_map.svh"
module tb_top;
   import cdc_seq_pkg::*;
   logic        i_clock, i_rst_n, i_wr, i_rd, pin, dtrig, dend, hit;
   logic        timing, done, busy, slow;
   logic [7:0]  i_addr;
   logic [31:0] i_wdata, rdata;
   logic [9:0]  sw;
   logic [4:0]  rl, rc;
   logic [3:0]  rh;
   logic        ptim;
   phase_t      phase, prev;
   int          mismatches, cmp_count, n_done, n_dis, n_int;
   int          n_tdc, n_hit, n_ref;
   cdc_measurement_sequencer u_cdc_measurement_sequencer (.i_clock(i_clock),
      .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(rdata), .i_pin_trigger(pin),
      .i_dsp_trigger(dtrig), .i_dsp_end(dend), .i_reached(hit),
      .o_phase(phase), .o_tdc_timing(timing), .o_port_switch(sw),
      .o_res_low(rl), .o_res_high(rh), .o_slow_res_en(slow),
      .o_ref_cap(rc), .o_conv_done(done), .o_busy(busy));
   cdc_sensor_model u_cdc_sensor_model (.i_clock(i_clock), .i_phase(phase),
      .o_reached(hit));
   // ----------------------------
   // clock and event counters
   // ----------------------------
   initial begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      prev <= phase;
      if (done === 1'b1) n_done++;
      if (phase == PH_DIS && prev != PH_DIS) n_dis++;
      if (phase == PH_DIS && prev != PH_DIS && sw == 10'h000) n_int++;
      ptim <= timing;
      if (timing === 1'b1 && ptim === 1'b0) n_tdc++;
      if (timing === 1'b0 && ptim === 1'b1 && phase == PH_DIS) n_hit++;
      if (phase == PH_DIS && prev != PH_DIS && sw[9:8] != 2'b00) n_ref++;
   end
   // ----------------------------
   // bus and compare tasks
   // ----------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
      @(posedge i_clock);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      @(negedge i_clock);
      chk(rdata, exp);
      @(posedge i_clock);
   endtask
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // fire one trigger kind, refire while busy, then count the cycles
   task automatic conv(input int k, input int seqs, input int per);
      n_done = 0;
      n_dis = 0;
      n_int = 0;
      n_tdc = 0;
      n_hit = 0;
      n_ref = 0;
      if (k == 0) wr(`ADDR_COMMAND, 32'h0000_0001);
      if (k == 4) wr(`ADDR_PERIOD, 32'h0000_0001);
      pin <= (k == 2);
      dtrig <= (k == 1);
      dend <= (k == 3);
      @(posedge i_clock);
      {pin, dtrig, dend} <= 3'h0;
      repeat (60) @(posedge i_clock);
      chk(busy, 1'b1);
      if (k == 4) wr(`ADDR_PERIOD, 32'h0000_0000);
      wr(`ADDR_COMMAND, 32'h0000_0001);
      for (int i = 0; i < 10000 && n_done == 0; i++) @(posedge i_clock);
      repeat (300) @(posedge i_clock);
      if (n_done == 0) begin
         mismatches++;
         conclude();
      end
      chk(n_done, 1);
      chk(n_dis, per * seqs);
      chk(n_int, seqs);
      chk(n_tdc, per * seqs);
      chk(n_hit, (k == 4) ? 0 : per * seqs);
      chk(busy, 1'b0);
      $display("test trigger %0d done", k);
   endtask
   // ----------------------------
   // main sequence
   // ----------------------------
   initial begin
      {i_rst_n, i_wr, i_rd, pin, dtrig, dend} = 6'h00;
      i_addr = 8'h00;
      i_wdata = 32'h0;
      repeat (12) @(posedge i_clock);
      i_rst_n <= 1'b1;
      @(posedge i_clock);
      rd(`ADDR_CONFIG, `CONFIG_RESET);
      rd(`ADDR_SEQUENCE, `SEQUENCE_RESET);
      rd(`ADDR_TIMES, `TIMES_RESET);
      rd(8'h1C, 32'h0);
      chk(rc, 5'h01);
      chk(rl, 5'h01);
      chk(rh, 4'h1);
      chk(slow, 1'b0);
      $display("test reset done");
      conv(0, 1, 3);
      wr(`ADDR_SEQUENCE, 32'h0000_1F11);
      rd(`ADDR_SEQUENCE, 32'h0000_1F11);
      conv(1, 3, 3);
      chk(rl, 5'h10);
      chk(rh, 4'h8);
      wr(`ADDR_SEQUENCE, 32'h0);
      wr(`ADDR_CONFIG, 32'h00FB_9003);
      conv(2, 1, 3);
      chk(slow, 1'b1);
      chk(rc, 5'h1F);
      wr(`ADDR_DSP_PARAM, 32'h0000_0002);
      conv(3, 1, 3);
      wr(`ADDR_CONFIG, 32'h0008_3A0F);
      wr(`ADDR_PERIOD, 32'h0000_0001);
      conv(0, 1, 7);
      chk(n_ref, 3);
      wr(`ADDR_PERIOD, 32'h0);
      wr(`ADDR_CONFIG, 32'h000D_1003);
      conv(4, 1, 3);
      conclude();
   end
endmodule
